// ---- logic/lsp_top.sv ----
// limit switch and slowdown sensor positioning logic with axi4-lite registers
// What this block does
// - stop-limit input at zero commands a stop
// - stop-limit stop uses the configured stop type
// - after stop, only opposite direction, after standstill
// - both stop limits active blocks every restart
// - stop types ramp, fast, freewheel; freewheel default
// - sensor active edge selectable rising or falling
// - forward slowdown edge clamps reference to low speed
// - reverse stays at full speed in slowdown zone
// - opposite edge while reversing clears forward slowdown
// - slowdown state kept in non-volatile storage
// - input or control bit can disable positioning
// - disable suppresses slowdown but tracking continues
// - same logic for forward and reverse
// - zone unknown after switches are configured
// - long cams: initialise anywhere on trajectory
// - save zone at switch-off, restore at power-up
// - distance stop from rated and tripping speed
// - stop limit overrides the distance stop
// - stop source unassigned, control bits, or inputs low
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
module lsp_top
   import lsp_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // axi4-lite write address and data
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // axi4-lite read
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // digital input pins di1..di16
   input wire logic [15:0] DI_I,
   // zone retention memory
   input wire logic POWER_FAIL_I,
   input wire logic [2:0] ZONE_NV_I,
   input wire logic ZONE_NV_VALID_I,
   output logic ZONE_SAVE_O,
   output logic [2:0] ZONE_DATA_O,
   // motor control side, same clock
   input wire logic RUN_FWD_I,
   input wire logic RUN_REV_I,
   input wire logic STANDSTILL_I,
   input wire logic [15:0] SPEED_EST_I,
   input wire logic [15:0] SPEED_REF_I,
   output logic [15:0] SPEED_LIMITED_O,
   output logic FWD_INHIBIT_O,
   output logic REV_INHIBIT_O,
   output logic STOP_REQ_O,
   output logic [1:0] STOP_TYPE_O
);
   // the whole state of the block
   typedef struct packed {
      // bus slave
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      // software registers
      logic [31:0] stop_assign;
      logic [31:0] sens_assign;
      lsp_stop_type stop_type;
      logic rising;
      logic long_cam;
      logic dist_mode;
      logic [15:0] low_speed;
      logic [15:0] high_speed;
      logic [31:0] distance;
      logic [15:0] rated;
      logic [15:0] cword;
      // sensor tracking
      logic fslow_prev;
      logic rslow_prev;
      logic fstop_prev;
      logic rstop_prev;
      logic fwd_slow;
      logic rev_slow;
      logic zone_known;
      logic stop_hold;
      logic pfail_prev;
      logic [1:0] restore_cnt;
      logic restored;
      // distance stop
      logic dist_run;
      logic dist_stop;
      logic [15:0] trip_speed;
      logic [47:0] travel;
      // outputs
      logic zone_save;
      logic [2:0] zone_data;
      logic [15:0] speed_lim;
      logic fwd_inh;
      logic rev_inh;
      logic stop_req;
      logic [1:0] stop_out;
   } lsp_state_type;

   lsp_state_type state; // registered state
   lsp_state_type next_state; // next value
   logic [20:0] sync_in; // pins before crossing
   logic [20:0] sync_out; // pins after crossing
   logic [15:0] di; // clean digital inputs
   logic pfail; // clean power fail
   logic [2:0] nv_zone; // clean stored zone
   logic nv_valid; // clean stored zone valid

   // pick one source: bit 1 is assigned, bit 0 the level
   function automatic logic [1:0] src_level(input logic [5:0] sel, input logic [15:0] pins,
                                            input logic [15:0] bits);
      logic [5:0] k;
      k = 6'h00;
      if (sel >= LSP_SRC_DI_FIRST && sel <= LSP_SRC_DI_LAST) begin
         k = sel - LSP_SRC_DI_FIRST;
         return {1'b1, pins[k[3:0]]};
      end else if (sel >= LSP_SRC_CW_FIRST && sel <= LSP_SRC_CW_LAST) begin
         k = sel - LSP_SRC_CW_FIRST;
         return {1'b1, bits[k[3:0]]};
      end
      return 2'b01; // unassigned idles high, so never active
   endfunction

   // merge a write word into a register under byte strobes
   function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction

   // every outside level crosses two flops before use
   assign sync_in = {ZONE_NV_VALID_I, ZONE_NV_I, POWER_FAIL_I, DI_I};
   lsp_sync #(.WIDTH(21)) u_sync (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .async_i(sync_in),
      .sync_o(sync_out)
   );
   assign di = sync_out[15:0];
   assign pfail = sync_out[16];
   assign nv_zone = sync_out[19:17];
   assign nv_valid = sync_out[20];

   // next state of the whole block
   always_comb begin
      logic [1:0] fstop;
      logic [1:0] rstop;
      logic [1:0] fslow;
      logic [1:0] rslow;
      logic [1:0] dis;
      logic fstop_act;
      logic rstop_act;
      logic disabled;
      logic act_lvl;
      logic f_act_edge;
      logic f_opp_edge;
      logic r_act_edge;
      logic r_opp_edge;
      logic cfg_write;
      logic do_write;
      logic [31:0] merged;
      logic [31:0] status;
      logic [47:0] margin;
      logic [15:0] cap;
      fstop = 2'b01;
      rstop = 2'b01;
      fslow = 2'b01;
      rslow = 2'b01;
      dis = 2'b01;
      cfg_write = 1'b0;
      merged = 32'h0000_0000;
      status = 32'h0000_0000;
      margin = 48'h0000_0000_0000;
      cap = 16'h0000;
      fstop_act = 1'b0;
      rstop_act = 1'b0;
      disabled = 1'b0;
      act_lvl = 1'b0;
      f_act_edge = 1'b0;
      f_opp_edge = 1'b0;
      r_act_edge = 1'b0;
      r_opp_edge = 1'b0;
      do_write = 1'b0;
      next_state = state;

      // source selection for every function
      fstop = src_level(state.stop_assign[LSP_POS_FWD_STOP +: 6], di, state.cword);
      rstop = src_level(state.stop_assign[LSP_POS_REV_STOP +: 6], di, state.cword);
      fslow = src_level(state.sens_assign[LSP_POS_FWD_SLOW +: 6], di, state.cword);
      rslow = src_level(state.sens_assign[LSP_POS_REV_SLOW +: 6], di, state.cword);
      dis = src_level(state.sens_assign[LSP_POS_DISABLE +: 6], di, state.cword);
      fstop_act = fstop[1] & ~fstop[0];
      rstop_act = rstop[1] & ~rstop[0];
      disabled = dis[1] & dis[0];

      // sensor edges against the previous sample
      act_lvl = state.rising; // level inside the zone
      f_act_edge = fslow[1] & (fslow[0] != state.fslow_prev) & (fslow[0] == act_lvl);
      f_opp_edge = fslow[1] & (fslow[0] != state.fslow_prev) & (fslow[0] != act_lvl);
      r_act_edge = rslow[1] & (rslow[0] != state.rslow_prev) & (rslow[0] == act_lvl);
      r_opp_edge = rslow[1] & (rslow[0] != state.rslow_prev) & (rslow[0] != act_lvl);
      next_state.fslow_prev = fslow[0];
      next_state.rslow_prev = rslow[0];
      next_state.fstop_prev = fstop_act;
      next_state.rstop_prev = rstop_act;

      // zone tracking runs even while disabled
      if (f_act_edge && RUN_FWD_I) begin
         next_state.fwd_slow = 1'b1;
      end else if (f_opp_edge && RUN_REV_I) begin
         next_state.fwd_slow = 1'b0;
      end
      if (r_act_edge && RUN_REV_I) begin
         next_state.rev_slow = 1'b1;
      end else if (r_opp_edge && RUN_FWD_I) begin
         next_state.rev_slow = 1'b0;
      end

      // zone initialisation
      if (!state.zone_known && state.restored) begin
         if (state.long_cam) begin
            // long cams: the level itself tells the zone
            next_state.fwd_slow = fslow[1] & (fslow[0] == act_lvl);
            next_state.rev_slow = rslow[1] & (rslow[0] == act_lvl);
            next_state.zone_known = 1'b1;
         end else if (!(fslow[1] && fslow[0] == act_lvl) && !(rslow[1] && rslow[0] == act_lvl)
                      && !fstop_act && !rstop_act) begin
            // short cams: only trust a start outside every zone
            next_state.fwd_slow = 1'b0;
            next_state.rev_slow = 1'b0;
            next_state.zone_known = 1'b1;
         end
      end

      // restore the stored zone shortly after power-up
      if (!state.restored) begin
         if (state.restore_cnt == LSP_RESTORE_WAIT) begin
            next_state.restored = 1'b1;
            if (nv_valid) begin
               next_state.fwd_slow = nv_zone[0];
               next_state.rev_slow = nv_zone[1];
               next_state.zone_known = nv_zone[2];
            end
         end else begin
            next_state.restore_cnt = state.restore_cnt + 2'h1;
         end
      end

      // save the zone when supply fails; one-cycle strobe
      next_state.zone_data = {next_state.zone_known, next_state.rev_slow, next_state.fwd_slow};
      next_state.zone_save = pfail & ~state.pfail_prev & state.restored;
      next_state.pfail_prev = pfail;

      // stop limits: hold until standstill, a new trip wins
      if ((fstop_act && !state.fstop_prev) || (rstop_act && !state.rstop_prev)) begin
         next_state.stop_hold = 1'b1;
      end else if (STANDSTILL_I) begin
         next_state.stop_hold = 1'b0;
      end

      // distance stop after the slowdown switch
      if (fstop_act || rstop_act || !(RUN_FWD_I || RUN_REV_I)) begin
         next_state.dist_run = 1'b0;
      end else if (state.dist_mode && ((f_act_edge && RUN_FWD_I) || (r_act_edge && RUN_REV_I))) begin
         next_state.dist_run = 1'b1;
         next_state.trip_speed = SPEED_EST_I;
         next_state.travel = 48'h0000_0000_0000;
      end else if (state.dist_run) begin
         // braking margin grows with the speed at trip time
         margin = 48'(state.trip_speed * state.rated) << LSP_DIST_MARGIN_SHIFT;
         next_state.travel = state.travel + 48'(SPEED_EST_I * state.rated);
         if (state.travel + margin >= {state.distance, 16'h0000}) begin
            next_state.dist_run = 1'b0;
            next_state.dist_stop = 1'b1;
         end
      end
      if (STANDSTILL_I && !state.dist_run) begin
         next_state.dist_stop = 1'b0;
      end

      // direction permits
      next_state.fwd_inh = fstop_act | (state.stop_hold & ~fstop_act & rstop_act);
      next_state.rev_inh = rstop_act | (state.stop_hold & ~rstop_act & fstop_act);
      if (fstop_act && rstop_act) begin
         next_state.fwd_inh = 1'b1;
         next_state.rev_inh = 1'b1;
      end
      // while a limit stop is still braking, hold the opposite run too
      if (state.stop_hold && !STANDSTILL_I) begin
         next_state.fwd_inh = 1'b1;
         next_state.rev_inh = 1'b1;
      end

      // stop request and its kind; the limit type wins over the distance ramp
      next_state.stop_req = (fstop_act & RUN_FWD_I) | (rstop_act & RUN_REV_I)
                            | state.stop_hold | (state.dist_stop & ~disabled);
      if ((fstop_act && RUN_FWD_I) || (rstop_act && RUN_REV_I) || state.stop_hold) begin
         next_state.stop_out = state.stop_type;
      end else begin
         next_state.stop_out = LSP_STOP_RAMP;
      end

      // speed cap: low speed only in the zone for the travel direction
      cap = state.high_speed;
      if (!disabled && state.zone_known &&
          ((state.fwd_slow && RUN_FWD_I) || (state.rev_slow && RUN_REV_I))) begin
         cap = state.low_speed;
      end
      next_state.speed_lim = (SPEED_REF_I > cap) ? cap : SPEED_REF_I;

      // axi write: take address and data in either order
      if (S_AXI_AWVALID_I && !state.aw_held) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !state.w_held) begin
         next_state.w_held = 1'b1;
         next_state.w_data = S_AXI_WDATA_I;
         next_state.w_strb = S_AXI_WSTRB_I;
      end
      do_write = state.aw_held & state.w_held & ~state.bvalid;
      if (do_write) begin
         next_state.aw_held = 1'b0;
         next_state.w_held = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = LSP_RESP_OKAY;
         unique case (state.aw_addr)
            LSP_OFF_STOP_ASSIGN: begin
               next_state.stop_assign = strobe_merge(state.stop_assign, state.w_data,
                                                     state.w_strb);
               cfg_write = 1'b1;
            end
            LSP_OFF_SENS_ASSIGN: begin
               next_state.sens_assign = strobe_merge(state.sens_assign, state.w_data,
                                                     state.w_strb);
               cfg_write = 1'b1;
            end
            LSP_OFF_CONFIG: begin
               merged = strobe_merge({27'h000_0000, state.dist_mode, state.long_cam,
                                      state.rising, state.stop_type}, state.w_data,
                                     state.w_strb);
               // illegal code falls back to the safe freewheel choice
               if (merged[LSP_POS_STOP_TYPE +: 2] == 2'h3) begin
                  next_state.stop_type = LSP_STOP_FREEWHEEL;
               end else begin
                  next_state.stop_type = lsp_stop_type'(merged[LSP_POS_STOP_TYPE +: 2]);
               end
               next_state.rising = merged[LSP_POS_RISING];
               next_state.long_cam = merged[LSP_POS_LONG_CAM];
               next_state.dist_mode = merged[LSP_POS_DIST_MODE];
               cfg_write = 1'b1;
            end
            LSP_OFF_SPEEDS: begin
               merged = strobe_merge({state.high_speed, state.low_speed}, state.w_data,
                                     state.w_strb);
               next_state.low_speed = merged[15:0];
               next_state.high_speed = merged[31:16];
            end
            LSP_OFF_DISTANCE: begin
               next_state.distance = strobe_merge(state.distance, state.w_data, state.w_strb);
            end
            LSP_OFF_RATED: begin
               merged = strobe_merge({16'h0000, state.rated}, state.w_data, state.w_strb);
               next_state.rated = merged[15:0];
            end
            LSP_OFF_CWORD: begin
               merged = strobe_merge({16'h0000, state.cword}, state.w_data, state.w_strb);
               next_state.cword = merged[15:0];
            end
            LSP_OFF_STATUS: begin
               next_state.bresp = LSP_RESP_OKAY; // read-only, write ignored
            end
            default: begin
               next_state.bresp = LSP_RESP_SLVERR;
            end
         endcase
      end
      if (state.bvalid && S_AXI_BREADY_I) begin
         next_state.bvalid = 1'b0;
      end
      // new switch setup makes the position unknown
      if (cfg_write) begin
         next_state.zone_known = 1'b0;
         next_state.fwd_slow = 1'b0;
         next_state.rev_slow = 1'b0;
      end

      // axi read: answer one cycle after the address is taken
      status = {state.trip_speed, 7'h00, disabled, state.dist_stop, state.rev_inh, state.fwd_inh,
                state.zone_known, state.rev_slow, state.fwd_slow, rstop_act, fstop_act};
      if (S_AXI_ARVALID_I && !state.rvalid) begin
         next_state.rvalid = 1'b1;
         next_state.rresp = LSP_RESP_OKAY;
         unique case (S_AXI_ARADDR_I)
            LSP_OFF_STOP_ASSIGN: next_state.rdata = state.stop_assign;
            LSP_OFF_SENS_ASSIGN: next_state.rdata = state.sens_assign;
            LSP_OFF_CONFIG: next_state.rdata = {27'h000_0000, state.dist_mode, state.long_cam,
                                                state.rising, state.stop_type};
            LSP_OFF_SPEEDS: next_state.rdata = {state.high_speed, state.low_speed};
            LSP_OFF_DISTANCE: next_state.rdata = state.distance;
            LSP_OFF_RATED: next_state.rdata = {16'h0000, state.rated};
            LSP_OFF_CWORD: next_state.rdata = {16'h0000, state.cword};
            LSP_OFF_STATUS: next_state.rdata = status;
            default: begin
               next_state.rdata = 32'h0000_0000;
               next_state.rresp = LSP_RESP_SLVERR;
            end
         endcase
      end else if (state.rvalid && S_AXI_RREADY_I) begin
         next_state.rvalid = 1'b0;
      end
   end

   // single state register; reset gives freewheel and an unknown zone
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state <= '0;
         state.stop_assign <= LSP_RST_ASSIGN;
         state.sens_assign <= LSP_RST_ASSIGN;
         state.stop_type <= LSP_STOP_FREEWHEEL;
         state.low_speed <= LSP_RST_LOW_SPEED;
         state.high_speed <= LSP_RST_HIGH_SPEED;
         state.distance <= LSP_RST_DISTANCE;
         state.rated <= LSP_RST_RATED;
         state.cword <= LSP_RST_CWORD;
         state.fslow_prev <= 1'b1;
         state.rslow_prev <= 1'b1;
         state.stop_out <= LSP_STOP_FREEWHEEL;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from the state register
   assign S_AXI_AWREADY_O = ~state.aw_held;
   assign S_AXI_WREADY_O = ~state.w_held;
   assign S_AXI_BVALID_O = state.bvalid;
   assign S_AXI_BRESP_O = state.bresp;
   assign S_AXI_ARREADY_O = ~state.rvalid;
   assign S_AXI_RVALID_O = state.rvalid;
   assign S_AXI_RDATA_O = state.rdata;
   assign S_AXI_RRESP_O = state.rresp;
   assign ZONE_SAVE_O = state.zone_save;
   assign ZONE_DATA_O = state.zone_data;
   assign SPEED_LIMITED_O = state.speed_lim;
   assign FWD_INHIBIT_O = state.fwd_inh;
   assign REV_INHIBIT_O = state.rev_inh;
   assign STOP_REQ_O = state.stop_req;
   assign STOP_TYPE_O = state.stop_out;
endmodule

// ---- logic/lsp_pkg.sv ----
// shared constants and types for the limit switch positioning block
package lsp_pkg;
   // register byte offsets
   localparam logic [7:0] LSP_OFF_STOP_ASSIGN = 8'h00;
   localparam logic [7:0] LSP_OFF_SENS_ASSIGN = 8'h04;
   localparam logic [7:0] LSP_OFF_CONFIG = 8'h08;
   localparam logic [7:0] LSP_OFF_SPEEDS = 8'h0C;
   localparam logic [7:0] LSP_OFF_DISTANCE = 8'h10;
   localparam logic [7:0] LSP_OFF_RATED = 8'h14;
   localparam logic [7:0] LSP_OFF_CWORD = 8'h18;
   localparam logic [7:0] LSP_OFF_STATUS = 8'h1C;
   // source field positions (6 bits each)
   localparam int LSP_POS_FWD_STOP = 0;
   localparam int LSP_POS_REV_STOP = 8;
   localparam int LSP_POS_FWD_SLOW = 0;
   localparam int LSP_POS_REV_SLOW = 8;
   localparam int LSP_POS_DISABLE = 16;
   // config field positions
   localparam int LSP_POS_STOP_TYPE = 0;
   localparam int LSP_POS_RISING = 2;
   localparam int LSP_POS_LONG_CAM = 3;
   localparam int LSP_POS_DIST_MODE = 4;
   // source selector codes
   localparam logic [5:0] LSP_SRC_NONE = 6'h00;
   localparam logic [5:0] LSP_SRC_DI_FIRST = 6'h01;
   localparam logic [5:0] LSP_SRC_DI_LAST = 6'h10;
   localparam logic [5:0] LSP_SRC_CW_FIRST = 6'h20;
   localparam logic [5:0] LSP_SRC_CW_LAST = 6'h2F;
   // reset values
   localparam logic [31:0] LSP_RST_ASSIGN = 32'h0000_0000;
   localparam logic [15:0] LSP_RST_LOW_SPEED = 16'h0000;
   localparam logic [15:0] LSP_RST_HIGH_SPEED = 16'h01F4;
   localparam logic [31:0] LSP_RST_DISTANCE = 32'h0000_0000;
   localparam logic [15:0] LSP_RST_RATED = 16'h0000;
   localparam logic [15:0] LSP_RST_CWORD = 16'h0000;
   // distance stop: braking margin is trip speed times rated speed, shifted
   localparam int LSP_DIST_MARGIN_SHIFT = 4;
   // cycles after reset before the stored zone is taken from the synchroniser
   localparam logic [1:0] LSP_RESTORE_WAIT = 2'h3;
   // axi response codes
   localparam logic [1:0] LSP_RESP_OKAY = 2'h0;
   localparam logic [1:0] LSP_RESP_SLVERR = 2'h2;
   // stop type choices
   typedef enum logic [1:0] {
      LSP_STOP_RAMP,
      LSP_STOP_FAST,
      LSP_STOP_FREEWHEEL
   } lsp_stop_type;
endpackage

// ---- logic/lsp_sync.sv ----
// two flip-flop synchroniser for a group of slow outside levels
module lsp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   // first stage, read only by the second
   logic [WIDTH-1:0] meta;

   // plain double register; edges are found downstream on the clean copy
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// ---- tb/lsp_sva.sv ----
// concurrent checks on the limit switch block ports
module lsp_sva (
   // watched ports of the top module
   input wire logic CLK_I, RSTN_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I, S_AXI_BVALID_O, S_AXI_BREADY_I, POWER_FAIL_I,
   input wire logic ZONE_SAVE_O, STOP_REQ_O, FWD_INHIBIT_O, REV_INHIBIT_O,
   input wire logic [15:0] SPEED_REF_I, SPEED_LIMITED_O,
   input wire logic [1:0] STOP_TYPE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   // a clamp may only lower the request
   a_cap_ref: assert property (SPEED_LIMITED_O <= $past(SPEED_REF_I))
      else $error("speed above reference");
   a_type_code: assert property (STOP_TYPE_O != 2'h3)
      else $error("stop type code 3 driven");
   a_save_pulse: assert property (ZONE_SAVE_O |=> !ZONE_SAVE_O)
      else $error("zone save longer than one cycle");
   // sync plus edge detect plus register stays well inside six cycles
   a_save_cause: assert property ($rose(POWER_FAIL_I) |-> ##[1:6] ZONE_SAVE_O)
      else $error("no zone save after power fail");
   a_stop_blocks: assert property ($rose(STOP_REQ_O) && STOP_TYPE_O != 2'h0 |->
      FWD_INHIBIT_O || REV_INHIBIT_O)
      else $error("stop without direction inhibit");
   a_ar_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read answer late");
   a_r_done: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
      else $error("read answer repeated");
   a_b_done: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
      else $error("write answer repeated");
   // main scenarios reached
   c_stop: cover property (STOP_REQ_O && FWD_INHIBIT_O);
   c_both: cover property (FWD_INHIBIT_O && REV_INHIBIT_O);
   c_save: cover property (ZONE_SAVE_O);
endmodule

// ---- tb/lsp_switches.sv ----
// switch and sensor model along the carriage trajectory
module lsp_switches (
   // carriage position, cut cable fault, contacts
   input wire logic signed [15:0] pos_i,
   input wire logic both_open_i,
   output logic [15:0] di_o
);
   // spare inputs pulled up; stop contacts open past 19, slowdown cams low past 9
   assign di_o = {12'hFFF, pos_i > -16'sd10, pos_i < 16'sd10,
      !(pos_i < -16'sd19 || both_open_i), !(pos_i > 16'sd19 || both_open_i)};
endmodule

// ---- tb/limit_switch_positioning_tb.sv ----
// self-checking bench for the limit switch positioning block
module limit_switch_positioning_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lsp_pkg::*;
   logic CLK_I = 1'b0;
   logic RSTN_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I;
   logic S_AXI_RREADY_I, S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
   logic S_AXI_RVALID_O, ZONE_NV_VALID_I, ZONE_SAVE_O, POWER_FAIL_I, RUN_FWD_I, RUN_REV_I;
   logic STANDSTILL_I, FWD_INHIBIT_O, REV_INHIBIT_O, STOP_REQ_O, both, done;
   logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
   logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O, rd;
   logic [3:0] S_AXI_WSTRB_I;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, STOP_TYPE_O, rsp;
   logic [2:0] ZONE_NV_I, ZONE_DATA_O, rdy;
   logic [15:0] DI_I, SPEED_EST_I, SPEED_REF_I, SPEED_LIMITED_O;
   logic signed [15:0] pos;
   int err_count, tests_run, t;
   lsp_switches sw (.pos_i(pos), .both_open_i(both), .di_o(DI_I));
   lsp_top uut (.*);
   initial forever #12.5 CLK_I = ~CLK_I;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) err_count++;
      if (got !== exp) $display("mismatch at %0t got %h exp %h", $time, got, exp);
   endtask
   // one bus access; readies sampled mid-cycle so valids drop after their edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I} <= {a, a, d};
      {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= {3{w}};
      {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= {2{!w}};
      do begin
         @(negedge CLK_I);
         {done, rsp} = w ? {S_AXI_BVALID_O, S_AXI_BRESP_O} : {S_AXI_RVALID_O, S_AXI_RRESP_O};
         {rd, rdy} = {S_AXI_RDATA_O, S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_ARREADY_O};
         @(posedge CLK_I);
         {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_ARVALID_I} <=
            {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_ARVALID_I} & ~rdy;
      end while (!done);
      {S_AXI_BREADY_I, S_AXI_RREADY_I} <= 2'h0;
   endtask
   // motion inputs {fwd, rev, still, cut, power fail}; pins need four cycles
   task automatic go(input logic [4:0] m, input logic signed [15:0] p);
      @(posedge CLK_I);
      {RUN_FWD_I, RUN_REV_I, STANDSTILL_I, both, POWER_FAIL_I, pos} <= {m, p};
      repeat (6) @(posedge CLK_I);
      @(negedge CLK_I);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // hang guard, far above the roughly 160 cycles used
   initial begin
      repeat (5000) @(posedge CLK_I);
      err_count++;
      finish_test();
   end
   initial begin
      {RSTN_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I} = 5'h00;
      {S_AXI_RREADY_I, RUN_FWD_I, RUN_REV_I, STANDSTILL_I, both, POWER_FAIL_I} = 6'h00;
      {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I, ZONE_NV_I, ZONE_NV_VALID_I} = '0;
      {S_AXI_WSTRB_I, SPEED_EST_I, SPEED_REF_I} = {4'hF, 16'h0000, 16'h03E8};
      pos = 16'h0000; // start outside every zone
      repeat (8) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      xfer(1'b0, LSP_OFF_CONFIG, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      xfer(1'b0, 8'h20, 32'h0000_0000);
      check(32'(rsp), 32'(LSP_RESP_SLVERR));
      xfer(1'b1, LSP_OFF_STOP_ASSIGN, 32'h0000_0201);
      check(32'(rsp), 32'(LSP_RESP_OKAY));
      xfer(1'b1, LSP_OFF_SENS_ASSIGN, 32'h0000_0403);
      xfer(1'b1, LSP_OFF_CONFIG, 32'h0000_0001);
      go(5'h10, 16'h000C);
      check(32'(SPEED_LIMITED_O), 32'(LSP_RST_LOW_SPEED));
      go(5'h08, 16'h000C);
      check(32'(SPEED_LIMITED_O), 32'(LSP_RST_HIGH_SPEED));
      go(5'h08, 16'h0000);
      xfer(1'b0, LSP_OFF_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_0014, 32'h0000_0010);
      xfer(1'b1, LSP_OFF_SENS_ASSIGN, 32'h0020_0403);
      xfer(1'b1, LSP_OFF_CWORD, 32'h0000_0001);
      go(5'h10, 16'h000C);
      check(32'(SPEED_LIMITED_O), 32'(LSP_RST_HIGH_SPEED));
      xfer(1'b1, LSP_OFF_CWORD, 32'h0000_0000);
      go(5'h10, 16'h0016);
      check(32'({STOP_REQ_O, FWD_INHIBIT_O, STOP_TYPE_O}), 32'h0000_000D);
      go(5'h04, 16'h0016);
      check(32'({FWD_INHIBIT_O, REV_INHIBIT_O}), 32'h0000_0002);
      for (t = 0; t < 4; t++) begin
         xfer(1'b1, LSP_OFF_CONFIG, 32'(t));
         go(5'h14, 16'h0016);
         check(32'(STOP_TYPE_O), (t == 3) ? 32'h0000_0002 : 32'(t));
      end
      go(5'h06, 16'h0016);
      check(32'({FWD_INHIBIT_O, REV_INHIBIT_O}), 32'h0000_0003);
      go(5'h07, 16'h0016);
      @(posedge CLK_I);
      {ZONE_NV_I, ZONE_NV_VALID_I, RSTN_I} <= 5'h16;
      repeat (8) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      go(5'h00, 16'h0000);
      check(32'(ZONE_DATA_O), 32'h0000_0005);
      finish_test();
   end
endmodule
bind lsp_top lsp_sva chk_u (.*);
